// [design/asru_rate_gen.sv]
// Base clock generator: divider with periodic cycle dropping
`timescale 1ns/10ps
module asru_rate_gen #(
    parameter int W_DIV = 16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Configuration
    input wire logic [15:0] i_div,
    input wire logic [7:0] i_keep,
    input wire logic [7:0] i_per,
    // Base clock pulse
    output logic o_tick
);
    asru_pkg::asru_rg_type s;
    asru_pkg::asru_rg_type n;
    logic dv;
    logic chg;
    logic [8:0] sum;

    generate
        if (W_DIV != 16) begin : g_chk
            $error("asru_rate_gen: W_DIV must be 16");
        end
    endgenerate

    // Compare all 32 settings bits, so a wide divider is not seen as a change every cycle
    assign chg = {i_div, i_keep, i_per} != s.cfg;
    assign dv = s.pre >= i_div - 16'h0001;
    assign sum = {1'b0, s.acc} + {1'b0, i_keep};

    always_comb begin
        n = s;
        n.tick = 1'b0;
        n.cfg = {i_div, i_keep, i_per};
        n.pre = dv ? 16'h0000 : s.pre + 16'h0001;
        if (chg) begin
            n.pre = 16'h0000;
            n.acc = 8'h00;
            n.n_div = 8'h00;
            n.n_tick = 8'h00;
        end else if (dv) begin
            // Spread drops evenly; with 47 of 51 kept no bit holds two of them
            if (sum >= {1'b0, i_per}) begin
                n.acc = 8'(sum - {1'b0, i_per});
                n.tick = 1'b1;
            end else begin
                n.acc = sum[7:0];
            end
            n.n_div = (s.n_div == i_per - 8'h01) ? 8'h00 : s.n_div + 8'h01;
            n.n_tick = (s.n_div == i_per - 8'h01) ? 8'h00 : s.n_tick + 8'(n.tick);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_tick = s.tick;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    property p_keep_ratio;
        (dv && !chg && s.n_div == i_per - 8'h01) |-> (s.n_tick + 8'(n.tick) == i_keep);
    endproperty
    a_keep_ratio: assert property (p_keep_ratio)
        else $error("base clock kept cycles per period mismatch");
endmodule : asru_rate_gen

// [design/asru_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module asru_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [2*W-1:0] st;
    logic [2*W-1:0] next_st;

    generate
        if (W < 1) begin : g_chk
            $error("asru_sync: W must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_comb begin
        next_st = {st[W-1:0], i_d};
    end

    // Idle-high lines reset to one
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign o_q = st[2*W-1:W];
endmodule : asru_sync

// [design/asru_uart.sv]
// Asynchronous serial channel with average transfer rate generator
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "asru_map.svh"
module asru_uart (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // AXI4-Lite write
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Serial pins
    input wire logic i_rx_line,
    output logic o_tx_line,
    input wire logic i_timer_out_clock,
    input wire logic i_ext_clk
);
    localparam asru_pkg::asru_state_type P_RST = '{
        fmt: `ASRU_RST_REG, ctrl: `ASRU_RST_REG, card: `ASRU_RST_REG,
        ext: `ASRU_RST_REG, brr: `ASRU_RST_BRR, txd: `ASRU_RST_REG,
        rxd: `ASRU_RST_REG, flags: `ASRU_RST_FLAGS,
        tx_st: asru_pkg::ASRU_TX_IDLE, tx_sh: 10'h3ff, tx_bit: 4'h0,
        tx_tick: 3'h0, rx_st: asru_pkg::ASRU_RX_IDLE, rx_sh: 9'h000,
        rx_bit: 4'h0, rx_tick: 3'h0, aw_ok: 1'b0, aw_adr: 8'h00,
        w_ok: 1'b0, w_dat: 8'h00, w_stb: 1'b0, bvalid: 1'b0,
        bresp: 2'h0, rvalid: 1'b0, rresp: 2'h0, rdata: 8'h00,
        pin_prev: 2'h3};

    logic [1:0] rst_q;
    logic rst_n;
    asru_pkg::asru_state_type s;
    asru_pkg::asru_state_type n;
    logic [2:0] pins;
    logic rxs;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_wr;
    logic wr_ok;
    logic [8:0] rd_res;
    logic [8:0] wr_res;
    logic [15:0] rg_div;
    logic [7:0] rg_keep;
    logic [7:0] rg_per;
    logic rg_tick;
    logic avg_on;
    logic tmo_on;
    logic ext_on;
    logic tk;
    logic tx_load;
    logic fd;

    // Reset is released through two flops
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    asru_sync #(
        .W(3)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_d({i_ext_clk, i_timer_out_clock, i_rx_line}),
        .o_q(pins)
    );
    assign rxs = pins[0];

    // All eight registers are readable; shifters have no address
    function automatic logic [8:0] rd_dec(input logic [7:0] a,
                                          input asru_pkg::asru_state_type st);
        logic [8:0] r;
        r = 9'h000;
        case (a)
            `ASRU_OFS_FMT: r = {1'b1, st.fmt};
            `ASRU_OFS_CTRL: r = {1'b1, st.ctrl};
            `ASRU_OFS_FLAGS: r = {1'b1, st.flags & `ASRU_FL_MASK};
            `ASRU_OFS_TXD: r = {1'b1, st.txd};
            `ASRU_OFS_RXD: r = {1'b1, st.rxd};
            `ASRU_OFS_CARD: r = {1'b1, st.card};
            `ASRU_OFS_EXT: r = {1'b1, st.ext};
            `ASRU_OFS_BRR: r = {1'b1, st.brr};
            default: r = 9'h000;
        endcase
        return r;
    endfunction : rd_dec

    assign o_awready = !s.aw_ok && !s.bvalid;
    assign o_wready = !s.w_ok && !s.bvalid;
    assign o_arready = !s.rvalid;
    assign aw_take = i_awvalid && o_awready;
    assign w_take = i_wvalid && o_wready;
    assign ar_take = i_arvalid && o_arready;
    assign do_wr = s.aw_ok && s.w_ok && !s.bvalid;
    assign wr_res = rd_dec(s.aw_adr, s);
    assign wr_ok = wr_res[8];
    assign rd_res = rd_dec(i_araddr, s);

    // Base clock source selection
    always_comb begin
        avg_on = 1'b0;
        rg_keep = 8'h01;
        rg_per = 8'h01;
        rg_div = 16'({8'h00, s.brr} + 16'h0001) << {s.fmt[1:0], 1'b0};
        // Sync mode blocks the average rate generator
        if (!s.fmt[`ASRU_FMT_SYNC]) begin
            // Rate set for a 16 MHz peripheral clock
            case (s.ext[3:0])
                `ASRU_ACS_115: begin
                    avg_on = 1'b1;
                    rg_div = `ASRU_DIV_115;
                    rg_keep = `ASRU_KEEP_47;
                    rg_per = `ASRU_PER_51;
                end
                `ASRU_ACS_460: begin
                    avg_on = 1'b1;
                    rg_div = `ASRU_DIV_460;
                    rg_keep = `ASRU_KEEP_47;
                    rg_per = `ASRU_PER_51;
                end
                `ASRU_ACS_921: begin
                    avg_on = 1'b1;
                    rg_div = `ASRU_DIV_921;
                    rg_keep = `ASRU_KEEP_47;
                    rg_per = `ASRU_PER_51;
                end
                `ASRU_ACS_720: begin
                    avg_on = 1'b1;
                    rg_div = `ASRU_DIV_720;
                    rg_keep = `ASRU_KEEP_18;
                    rg_per = `ASRU_PER_25;
                end
                default: avg_on = 1'b0;
            endcase
        end
    end

    assign tmo_on = !s.fmt[`ASRU_FMT_SYNC] && s.ext[3:0] == `ASRU_ACS_TMO;
    // Average rate always runs from the core clock, overriding clock select
    assign ext_on = s.ctrl[`ASRU_CTRL_CKE1] && !avg_on && !tmo_on;
    assign tk = tmo_on ? (pins[1] && !s.pin_prev[0]) :
                ext_on ? (pins[2] && !s.pin_prev[1]) : rg_tick;

    asru_rate_gen #(
        .W_DIV(16)
    ) u_rate (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_div(rg_div),
        .i_keep(rg_keep),
        .i_per(rg_per),
        .o_tick(rg_tick)
    );

    assign tx_load = s.tx_st == asru_pkg::ASRU_TX_IDLE && !s.flags[`ASRU_FL_TXE]
                     && s.ctrl[`ASRU_CTRL_TE];
    assign fd = s.rx_st == asru_pkg::ASRU_RX_DATA && tk && s.rx_tick == `ASRU_TICK_LAST
                && s.rx_bit == `ASRU_RX_STOP_BIT;

    always_comb begin
        n = s;
        n.pin_prev = pins[2:1];
        // Bus side first, so hardware sets below win over clears
        if (aw_take) begin
            n.aw_ok = 1'b1;
            n.aw_adr = i_awaddr;
        end
        if (w_take) begin
            n.w_ok = 1'b1;
            n.w_dat = i_wdata[7:0];
            n.w_stb = i_wstrb[0];
        end
        if (s.bvalid && i_bready) begin
            n.bvalid = 1'b0;
        end
        if (do_wr) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_ok ? `ASRU_RESP_OK : `ASRU_RESP_ERR;
            if (s.w_stb) begin
                case (s.aw_adr)
                    `ASRU_OFS_FMT: n.fmt = s.w_dat;
                    `ASRU_OFS_CTRL: n.ctrl = s.w_dat;
                    // Writing zero clears a flag; writing one leaves it
                    `ASRU_OFS_FLAGS: n.flags = s.flags & s.w_dat & `ASRU_FL_MASK;
                    `ASRU_OFS_TXD: begin
                        n.txd = s.w_dat;
                        n.flags[`ASRU_FL_TXE] = 1'b0;
                    end
                    `ASRU_OFS_CARD: n.card = s.w_dat;
                    `ASRU_OFS_EXT: n.ext = s.w_dat;
                    `ASRU_OFS_BRR: n.brr = s.w_dat;
                    default: n.bresp = `ASRU_RESP_ERR;
                endcase
            end
        end
        if (s.rvalid && i_rready) begin
            n.rvalid = 1'b0;
        end
        if (ar_take) begin
            n.rvalid = 1'b1;
            n.rdata = rd_res[7:0];
            n.rresp = rd_res[8] ? `ASRU_RESP_OK : `ASRU_RESP_ERR;
        end
        // Transmitter: shifter is internal only
        case (s.tx_st)
            asru_pkg::ASRU_TX_IDLE: begin
                if (tx_load) begin
                    n.tx_st = asru_pkg::ASRU_TX_SEND;
                    n.tx_sh = {1'b1, s.txd, 1'b0};
                    n.tx_bit = 4'h0;
                    n.tx_tick = 3'h0;
                    n.flags[`ASRU_FL_TXE] = 1'b1;
                end
            end
            asru_pkg::ASRU_TX_SEND: begin
                if (tk) begin
                    n.tx_tick = s.tx_tick + 3'h1;
                    if (s.tx_tick == `ASRU_TICK_LAST) begin
                        n.tx_sh = {1'b1, s.tx_sh[9:1]};
                        n.tx_bit = s.tx_bit + 4'h1;
                        if (s.tx_bit == `ASRU_TX_LAST_BIT) begin
                            // Next byte loads on the following cycle
                            n.tx_st = asru_pkg::ASRU_TX_IDLE;
                        end
                    end
                end
            end
            default: n.tx_st = asru_pkg::ASRU_TX_IDLE;
        endcase
        // Receiver samples mid-bit after a half-bit start check
        case (s.rx_st)
            asru_pkg::ASRU_RX_IDLE: begin
                if (!rxs && s.ctrl[`ASRU_CTRL_RE]) begin
                    n.rx_st = asru_pkg::ASRU_RX_START;
                    n.rx_tick = 3'h0;
                end
            end
            asru_pkg::ASRU_RX_START: begin
                if (tk) begin
                    n.rx_tick = s.rx_tick + 3'h1;
                    if (s.rx_tick == `ASRU_START_MID) begin
                        n.rx_st = rxs ? asru_pkg::ASRU_RX_IDLE : asru_pkg::ASRU_RX_DATA;
                        n.rx_tick = 3'h0;
                        n.rx_bit = 4'h0;
                    end
                end
            end
            asru_pkg::ASRU_RX_DATA: begin
                if (tk) begin
                    n.rx_tick = s.rx_tick + 3'h1;
                    if (s.rx_tick == `ASRU_TICK_LAST) begin
                        // LSB first: first data bit ends at the bottom
                        n.rx_sh = {rxs, s.rx_sh[8:1]};
                        n.rx_bit = s.rx_bit + 4'h1;
                    end
                end
                if (fd) begin
                    n.rx_st = asru_pkg::ASRU_RX_IDLE;
                    if (!rxs) begin
                        n.flags[`ASRU_FL_FER] = 1'b1;
                    end
                    // Old byte survives an unread overrun
                    if (s.flags[`ASRU_FL_RXF]) begin
                        n.flags[`ASRU_FL_ORE] = 1'b1;
                    end else begin
                        // Shifter keeps running while the byte waits
                        n.rxd = s.rx_sh[8:1];
                        n.flags[`ASRU_FL_RXF] = 1'b1;
                    end
                end
            end
            default: n.rx_st = asru_pkg::ASRU_RX_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= P_RST;
        end else begin
            s <= n;
        end
    end

    assign o_bvalid = s.bvalid;
    assign o_bresp = s.bresp;
    assign o_rvalid = s.rvalid;
    assign o_rresp = s.rresp;
    assign o_rdata = {24'h000000, s.rdata};
    assign o_tx_line = s.tx_sh[0];

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_tx_end;
        s.tx_st == asru_pkg::ASRU_TX_SEND && tk && s.tx_tick == `ASRU_TICK_LAST
        && s.tx_bit == `ASRU_TX_LAST_BIT;
    endsequence

    sequence s_next_ready;
        !s.flags[`ASRU_FL_TXE] && s.ctrl[`ASRU_CTRL_TE] ##1 s.ctrl[`ASRU_CTRL_TE];
    endsequence

    property p_rx_move;
        (fd && !s.flags[`ASRU_FL_RXF]) |=>
            (s.flags[`ASRU_FL_RXF] && s.rxd == $past(s.rx_sh[8:1]));
    endproperty
    a_rx_move: assert property (p_rx_move)
        else $error("received byte not moved to data register");

    property p_overrun;
        (fd && s.flags[`ASRU_FL_RXF]) |=> (s.flags[`ASRU_FL_ORE] && $stable(s.rxd));
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun did not keep earlier byte");

    property p_rxd_ro;
        (do_wr && s.aw_adr == `ASRU_OFS_RXD && !fd) |=> $stable(s.rxd);
    endproperty
    a_rxd_ro: assert property (p_rxd_ro)
        else $error("receive data register changed by a write");

    property p_tx_load;
        tx_load |=> (s.tx_st == asru_pkg::ASRU_TX_SEND && s.tx_sh[8:1] == $past(s.txd)
                     && !o_tx_line && s.flags[`ASRU_FL_TXE]);
    endproperty
    a_tx_load: assert property (p_tx_load)
        else $error("transmit shifter not loaded from data register");

    property p_back_to_back;
        (s_tx_end ##1 s_next_ready) |-> ##1 (s.tx_st == asru_pkg::ASRU_TX_SEND);
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("pending byte did not follow previous frame");

    property p_flags_clear_only;
        (do_wr && s.aw_adr == `ASRU_OFS_FLAGS && !fd && !tx_load) |=>
            ((s.flags & ~$past(s.flags)) == 8'h00);
    endproperty
    a_flags_clear_only: assert property (p_flags_clear_only)
        else $error("software write set a status flag");

    property p_bit_len;
        ($changed(o_tx_line) && $past(s.tx_st) == asru_pkg::ASRU_TX_SEND) |->
            ($past(tk) && $past(s.tx_tick) == `ASRU_TICK_LAST);
    endproperty
    a_bit_len: assert property (p_bit_len)
        else $error("transmit line changed inside a bit");

    property p_stop_check;
        (fd && !rxs) |=> s.flags[`ASRU_FL_FER];
    endproperty
    a_stop_check: assert property (p_stop_check)
        else $error("low stop bit not flagged");

    property p_sync_no_avg;
        s.fmt[`ASRU_FMT_SYNC] |-> (!avg_on && rg_keep == rg_per);
    endproperty
    a_sync_no_avg: assert property (p_sync_no_avg)
        else $error("average rate used outside asynchronous mode");
endmodule : asru_uart

// [include/asru_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef ASRU_MAP_SVH
`define ASRU_MAP_SVH

`define ASRU_OFS_FMT 8'h00
`define ASRU_OFS_CTRL 8'h04
`define ASRU_OFS_FLAGS 8'h08
`define ASRU_OFS_TXD 8'h0c
`define ASRU_OFS_RXD 8'h10
`define ASRU_OFS_CARD 8'h14
`define ASRU_OFS_EXT 8'h18
`define ASRU_OFS_BRR 8'h1c

`define ASRU_FMT_SYNC 7
`define ASRU_CTRL_TIE 7
`define ASRU_CTRL_RIE 6
`define ASRU_CTRL_TE 5
`define ASRU_CTRL_RE 4
`define ASRU_CTRL_CKE1 1
`define ASRU_FL_TXE 7
`define ASRU_FL_RXF 6
`define ASRU_FL_ORE 5
`define ASRU_FL_FER 4
`define ASRU_FL_PER 3
`define ASRU_FL_MASK 8'hf8
`define ASRU_CARD_SMIF 0

`define ASRU_RST_FLAGS 8'h80
`define ASRU_RST_BRR 8'hff
`define ASRU_RST_REG 8'h00

`define ASRU_ACS_115 4'h1
`define ASRU_ACS_460 4'h2
`define ASRU_ACS_921 4'h3
`define ASRU_ACS_720 4'h4
`define ASRU_ACS_TMO 4'h8
`define ASRU_DIV_115 16'h0010
`define ASRU_DIV_460 16'h0004
`define ASRU_DIV_921 16'h0002
`define ASRU_DIV_720 16'h0002
`define ASRU_KEEP_47 8'h2f
`define ASRU_PER_51 8'h33
`define ASRU_KEEP_18 8'h12
`define ASRU_PER_25 8'h19

`define ASRU_TICK_LAST 3'h7
`define ASRU_START_MID 3'h3
`define ASRU_TX_LAST_BIT 4'h9
`define ASRU_RX_STOP_BIT 4'h8
`define ASRU_RESP_OK 2'h0
`define ASRU_RESP_ERR 2'h2

`endif

// [include/asru_pkg.sv]
// Types shared by the serial channel modules
package asru_pkg;

    typedef enum logic [1:0] {
        ASRU_TX_IDLE = 2'b00,
        ASRU_TX_SEND = 2'b01
    } asru_tx_st_type;

    typedef enum logic [1:0] {
        ASRU_RX_IDLE = 2'b00,
        ASRU_RX_START = 2'b01,
        ASRU_RX_DATA = 2'b10
    } asru_rx_st_type;

    typedef struct packed {
        logic [7:0] fmt;
        logic [7:0] ctrl;
        logic [7:0] card;
        logic [7:0] ext;
        logic [7:0] brr;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic [7:0] flags;
        asru_tx_st_type tx_st;
        logic [9:0] tx_sh;
        logic [3:0] tx_bit;
        logic [2:0] tx_tick;
        asru_rx_st_type rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_bit;
        logic [2:0] rx_tick;
        logic aw_ok;
        logic [7:0] aw_adr;
        logic w_ok;
        logic [7:0] w_dat;
        logic w_stb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [1:0] pin_prev;
    } asru_state_type;

    typedef struct packed {
        logic [15:0] pre;
        logic [7:0] acc;
        logic tick;
        logic [31:0] cfg;
        logic [7:0] n_div;
        logic [7:0] n_tick;
    } asru_rg_type;

endpackage : asru_pkg

// [tb/asru_peer.sv]
// Remote serial peer: frames bytes onto the rx line and decodes the tx line
`timescale 1ns/10ps
module asru_peer #(
    parameter int BIT = 17,
    parameter int CLK_NS = 4
) (
    // Clock
    input wire logic i_core_clk,
    // Serial lines
    input wire logic i_line,
    output logic o_line
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    int run_len;
    time t0;
    // Line idles high between frames
    initial o_line = 1'b1;
    // A low stop level forces a framing error; the line is released high afterwards
    task send(input logic [7:0] v, input logic stop);
        logic [9:0] fr;
        fr = {stop, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= fr[i];
            repeat (BIT) @(posedge i_core_clk);
        end
        o_line <= 1'b1;
    endtask : send
    // Length of each low run; the last one of a 0x55 or 0xa3 frame is a single bit
    always begin
        @(negedge i_line);
        t0 = $time;
        @(posedge i_line);
        // Both edges land on clock edges, so the time span is a whole cycle count
        run_len = int'(($time - t0) / CLK_NS);
    end
    // Mid-bit sampling tolerates the few cycles of drift from dropped ticks
    always begin
        @(negedge i_line);
        repeat (BIT / 2) @(posedge i_core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_core_clk);
            b[i] = i_line;
        end
        repeat (BIT) @(posedge i_core_clk);
        rx_q.push_back(b);
    end
endmodule : asru_peer

// [tb/asru_uart_bench.sv]
// Register-level bench of the serial channel against the serial peer
`timescale 1ns/10ps
`include "asru_map.svh"
module asru_uart_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, tx_line, rx_line;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] d;
    logic [1:0] r;
    logic [3:0] codes [5] = '{`ASRU_ACS_115, `ASRU_ACS_460, `ASRU_ACS_720, `ASRU_ACS_TMO,
                              `ASRU_ACS_921};
    int n_mismatch = 0;
    int total_checks = 0;
    always #2 clk = ~clk;
    asru_uart u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_rx_line(rx_line), .o_tx_line(tx_line), .i_timer_out_clock(1'b0),
        .i_ext_clk(1'b0));
    asru_peer u_peer (.i_core_clk(clk), .i_line(tx_line), .o_line(rx_line));
    task test_done;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    // Address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= 4'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(d, e);
    endtask : rc
    // Bounded poll of one flag bit
    task poll(input int k);
        d = 8'h00;
        for (int i = 0; i < 300 && d[k] !== 1'b1; i++) rd(`ASRU_OFS_FLAGS);
    endtask : poll
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rc(`ASRU_OFS_FLAGS, `ASRU_RST_FLAGS);
        rc(`ASRU_OFS_RXD, 8'h00);
        rd(8'h20);
        chk({6'h0, r}, {6'h0, `ASRU_RESP_ERR});
        wr(8'h20, 8'h11);
        chk({6'h0, r}, {6'h0, `ASRU_RESP_ERR});
        wr(`ASRU_OFS_FMT, 8'h5a);
        rc(`ASRU_OFS_FMT, 8'h5a);
        wr(`ASRU_OFS_CARD, 8'h5a);
        rc(`ASRU_OFS_CARD, 8'h5a);
        // Last code left in place is the 921.569 kbps rate used by the frames below
        foreach (codes[i]) begin
            wr(`ASRU_OFS_EXT, {4'h0, codes[i]});
            rc(`ASRU_OFS_EXT, {4'h0, codes[i]});
        end
        wr(`ASRU_OFS_CTRL, 8'h30);
        rc(`ASRU_OFS_CTRL, 8'h30);
        wr(`ASRU_OFS_FLAGS, 8'hff);
        rc(`ASRU_OFS_FLAGS, 8'h80);
        wr(`ASRU_OFS_TXD, 8'h55);
        poll(`ASRU_FL_TXE);
        wr(`ASRU_OFS_TXD, 8'ha3);
        rc(`ASRU_OFS_TXD, 8'ha3);
        for (int i = 0; i < 3000 && u_peer.rx_q.size() < 2; i++) @(posedge clk);
        chk(u_peer.rx_q[0], 8'h55);
        chk(u_peer.rx_q[1], 8'ha3);
        chk(8'(u_peer.run_len == 16 || u_peer.run_len == 18), 8'h01);
        u_peer.send(8'h3c, 1'b1);
        poll(`ASRU_FL_RXF);
        rc(`ASRU_OFS_RXD, 8'h3c);
        wr(`ASRU_OFS_RXD, 8'hff);
        rc(`ASRU_OFS_RXD, 8'h3c);
        u_peer.send(8'h96, 1'b1);
        poll(`ASRU_FL_ORE);
        rc(`ASRU_OFS_FLAGS, 8'he0);
        rc(`ASRU_OFS_RXD, 8'h3c);
        wr(`ASRU_OFS_FLAGS, 8'h80);
        rc(`ASRU_OFS_FLAGS, 8'h80);
        // Low stop level: byte still stored, framing flagged
        u_peer.send(8'h5a, 1'b0);
        poll(`ASRU_FL_FER);
        rc(`ASRU_OFS_FLAGS, 8'hd0);
        rc(`ASRU_OFS_RXD, 8'h5a);
        // Synchronous mode must shut the average rate generator out
        wr(`ASRU_OFS_FMT, 8'h80);
        rc(`ASRU_OFS_FMT, 8'h80);
        test_done;
    end
endmodule : asru_uart_bench
